//--- verilog/tmr_pair_pkg.sv
`default_nettype none
package tmr_pair_pkg;
    // Register byte addresses
    localparam logic [7:0] LOWER_TIMER_CONTROL_ADDR = 8'h00;
    localparam logic [7:0] UPPER_TIMER_CONTROL_ADDR = 8'h04;
    localparam logic [7:0] LOWER_COUNT_ADDR = 8'h08;
    localparam logic [7:0] UPPER_COUNT_ADDR = 8'h0C;
    localparam logic [7:0] LOWER_PERIOD_ADDR = 8'h10;
    localparam logic [7:0] UPPER_PERIOD_ADDR = 8'h14;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'h18;
    localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h1C;
    localparam logic [7:0] IRQ_PRIORITY_ADDR = 8'h20;
    // Control register fields
    localparam int CTRL_RUN_BIT = 15;
    localparam int CTRL_IDLE_BIT = 13;
    localparam int CTRL_GATE_BIT = 6;
    localparam int CTRL_DIV_LSB = 4;
    localparam int CTRL_PAIR_BIT = 3;
    localparam int CTRL_SRC_BIT = 1;
    localparam logic [15:0] LOWER_CTRL_MASK = 16'hA07A;
    localparam logic [15:0] UPPER_CTRL_MASK = 16'hA072;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
    // Interrupt fields: bit 0 lower timer, bit 1 upper timer
    localparam int IRQ_LOWER_BIT = 0;
    localparam int IRQ_UPPER_BIT = 1;
    localparam int PRIO_W = 3;
    localparam int PRIO_UPPER_LSB = 3;
    // Prescaler
    localparam logic [1:0] DIV_BY_1 = 2'h0;
    localparam logic [1:0] DIV_BY_8 = 2'h1;
    localparam logic [1:0] DIV_BY_64 = 2'h2;
    localparam logic [7:0] TERM_DIV_1 = 8'h00;
    localparam logic [7:0] TERM_DIV_8 = 8'h07;
    localparam logic [7:0] TERM_DIV_64 = 8'h3F;
    localparam logic [7:0] TERM_DIV_256 = 8'hFF;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage
`default_nettype wire

//--- verilog/tmr_tick_gen.sv
`default_nettype none
module tmr_tick_gen #(
    parameter bit SYNC_AFTER = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic run_i,
    input wire logic ext_sel_i,
    input wire logic gate_en_i,
    input wire logic [1:0] div_sel_i,
    input wire logic pin_i,
    output logic tick_o,
    output logic gate_fall_o
);
    logic sync_a_r, sync_b_r, sync_c_r, pin_d_r, pre_tgl_r;
    logic [7:0] pre_cnt_r, pre_cnt_nxt, term;
    logic sync_in, sync_rise, sync_fall, pin_rise, pre_in, pre_out;
    logic post_sync;

    assign post_sync = SYNC_AFTER && ext_sel_i;
    // With the external source the lower timer syncs the divided clock; in every other case, and for the upper timer, the raw pin is synced
    assign sync_in = post_sync ? pre_tgl_r : pin_i;
    assign sync_rise = sync_b_r & ~sync_c_r;
    assign sync_fall = ~sync_b_r & sync_c_r;
    assign pin_rise = pin_i & ~pin_d_r;

    always_comb begin
        case (div_sel_i)
            tmr_pair_pkg::DIV_BY_1: term = tmr_pair_pkg::TERM_DIV_1;
            tmr_pair_pkg::DIV_BY_8: term = tmr_pair_pkg::TERM_DIV_8;
            tmr_pair_pkg::DIV_BY_64: term = tmr_pair_pkg::TERM_DIV_64;
            default: term = tmr_pair_pkg::TERM_DIV_256;
        endcase
    end

    always_comb begin
        if (ext_sel_i) begin
            pre_in = SYNC_AFTER ? pin_rise : sync_rise;
        end else begin
            pre_in = gate_en_i ? sync_b_r : 1'b1;
        end
    end

    assign pre_out = run_i & pre_in & (pre_cnt_r == term);
    assign pre_cnt_nxt = (pre_cnt_r == term) ? 8'h00 : pre_cnt_r + 8'h01;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync_a_r <= 1'b0;
            sync_b_r <= 1'b0;
            sync_c_r <= 1'b0;
            pin_d_r <= 1'b0;
        end else begin
            sync_a_r <= sync_in;
            sync_b_r <= sync_a_r;
            sync_c_r <= sync_b_r;
            pin_d_r <= pin_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pre_cnt_r <= 8'h00;
        end else if (!run_i) begin
            pre_cnt_r <= 8'h00;
        end else if (pre_in) begin
            pre_cnt_r <= pre_cnt_nxt;
        end
    end

    // Divided clock as a level so it can cross the synchroniser
    // While unused it tracks the chain, so selecting the pin source makes no false tick
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pre_tgl_r <= 1'b0;
        end else if (!post_sync) begin
            pre_tgl_r <= sync_b_r;
        end else if (pre_out) begin
            pre_tgl_r <= ~pre_tgl_r;
        end
    end

    assign tick_o = post_sync ? (run_i & (sync_b_r ^ sync_c_r)) : pre_out;
    assign gate_fall_o = run_i & gate_en_i & ~ext_sel_i & sync_fall;
endmodule
`default_nettype wire

//--- verilog/tmr_pair.sv
// Our own choices: the placing of the registers and the AHB-Lite register port.
`default_nettype none
module tmr_pair (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // AHB-Lite slave
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    // Timer pins and device state
    input wire logic LOWER_EXTERNAL_COUNT_PIN_I,
    input wire logic UPPER_EXTERNAL_COUNT_PIN_I,
    input wire logic IDLE_I,
    // Interrupt
    output logic IRQ_O,
    output logic [2:0] IRQ_PRIO_O
);
    logic [15:0] lower_ctrl_r, upper_ctrl_r, lower_count_r, upper_count_r;
    logic [15:0] lower_period_r, upper_period_r;
    logic [1:0] irq_status_r, irq_enable_r, irq_status_nxt, irq_set, irq_live;
    logic [5:0] irq_prio_r;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [31:0] rdata;
    logic addr_ok, pair, idle_lo, idle_hi;
    logic [1:0] run, ext_sel, gate_en, tick, gate_fall, pin;
    logic [1:0] div_sel [2];
    logic wr_ctrl_lo, wr_ctrl_hi, wr_cnt_lo, wr_cnt_hi, wr_per_lo, wr_per_hi;
    logic wr_stat, wr_en, wr_prio;
    logic [31:0] count32, period32;
    logic lo_match, hi_match, pair_match;

    // Bus address phase
    assign addr_ok = HSEL_I & HREADY_I & (HTRANS_I == tmr_pair_pkg::HTRANS_NONSEQ | HTRANS_I[1]);

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= addr_ok & HWRITE_I;
            wr_addr_r <= HADDR_I[7:0];
        end
    end

    assign wr_ctrl_lo = wr_pend_r && wr_addr_r == tmr_pair_pkg::LOWER_TIMER_CONTROL_ADDR;
    assign wr_ctrl_hi = wr_pend_r && wr_addr_r == tmr_pair_pkg::UPPER_TIMER_CONTROL_ADDR;
    assign wr_cnt_lo = wr_pend_r && wr_addr_r == tmr_pair_pkg::LOWER_COUNT_ADDR;
    assign wr_cnt_hi = wr_pend_r && wr_addr_r == tmr_pair_pkg::UPPER_COUNT_ADDR;
    assign wr_per_lo = wr_pend_r && wr_addr_r == tmr_pair_pkg::LOWER_PERIOD_ADDR;
    assign wr_per_hi = wr_pend_r && wr_addr_r == tmr_pair_pkg::UPPER_PERIOD_ADDR;
    assign wr_stat = wr_pend_r && wr_addr_r == tmr_pair_pkg::IRQ_STATUS_ADDR;
    assign wr_en = wr_pend_r && wr_addr_r == tmr_pair_pkg::IRQ_ENABLE_ADDR;
    assign wr_prio = wr_pend_r && wr_addr_r == tmr_pair_pkg::IRQ_PRIORITY_ADDR;

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            lower_ctrl_r <= tmr_pair_pkg::CTRL_RESET;
            upper_ctrl_r <= tmr_pair_pkg::CTRL_RESET;
            lower_period_r <= tmr_pair_pkg::PERIOD_RESET;
            upper_period_r <= tmr_pair_pkg::PERIOD_RESET;
            irq_enable_r <= 2'h0;
            irq_prio_r <= 6'h00;
        end else begin
            if (wr_ctrl_lo) begin
                lower_ctrl_r <= HWDATA_I[15:0] & tmr_pair_pkg::LOWER_CTRL_MASK;
            end
            if (wr_ctrl_hi) begin
                upper_ctrl_r <= HWDATA_I[15:0] & tmr_pair_pkg::UPPER_CTRL_MASK;
            end
            if (wr_per_lo) begin
                lower_period_r <= HWDATA_I[15:0];
            end
            if (wr_per_hi) begin
                upper_period_r <= HWDATA_I[15:0];
            end
            if (wr_en) begin
                irq_enable_r <= HWDATA_I[1:0];
            end
            if (wr_prio) begin
                irq_prio_r <= HWDATA_I[5:0];
            end
        end
    end

    // Read data is fetched in the address phase, so reads take no wait state
    always_comb begin
        rdata = 32'h0000_0000;
        if (HADDR_I[7:0] == tmr_pair_pkg::LOWER_TIMER_CONTROL_ADDR) begin
            rdata[15:0] = lower_ctrl_r;
        end else if (HADDR_I[7:0] == tmr_pair_pkg::UPPER_TIMER_CONTROL_ADDR) begin
            rdata[15:0] = upper_ctrl_r;
        end else if (HADDR_I[7:0] == tmr_pair_pkg::LOWER_COUNT_ADDR) begin
            rdata[15:0] = lower_count_r;
        end else if (HADDR_I[7:0] == tmr_pair_pkg::UPPER_COUNT_ADDR) begin
            rdata[15:0] = upper_count_r;
        end else if (HADDR_I[7:0] == tmr_pair_pkg::LOWER_PERIOD_ADDR) begin
            rdata[15:0] = lower_period_r;
        end else if (HADDR_I[7:0] == tmr_pair_pkg::UPPER_PERIOD_ADDR) begin
            rdata[15:0] = upper_period_r;
        end else if (HADDR_I[7:0] == tmr_pair_pkg::IRQ_STATUS_ADDR) begin
            rdata[1:0] = irq_status_r;
        end else if (HADDR_I[7:0] == tmr_pair_pkg::IRQ_ENABLE_ADDR) begin
            rdata[1:0] = irq_enable_r;
        end else if (HADDR_I[7:0] == tmr_pair_pkg::IRQ_PRIORITY_ADDR) begin
            rdata[5:0] = irq_prio_r;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            HRDATA_O <= 32'h0000_0000;
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
        end else begin
            HRDATA_O <= (addr_ok & ~HWRITE_I) ? rdata : 32'h0000_0000;
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
        end
    end

    // Effective controls: in pair mode the lower control word drives both halves, except the upper idle bit, which also halts the pair
    assign pair = lower_ctrl_r[tmr_pair_pkg::CTRL_PAIR_BIT];
    assign idle_lo = IDLE_I & lower_ctrl_r[tmr_pair_pkg::CTRL_IDLE_BIT];
    assign idle_hi = IDLE_I & upper_ctrl_r[tmr_pair_pkg::CTRL_IDLE_BIT];
    assign run[0] = lower_ctrl_r[tmr_pair_pkg::CTRL_RUN_BIT] & ~idle_lo & ~(pair & idle_hi);
    assign run[1] = ~pair & upper_ctrl_r[tmr_pair_pkg::CTRL_RUN_BIT] & ~idle_hi;
    assign pin[0] = LOWER_EXTERNAL_COUNT_PIN_I;
    assign pin[1] = UPPER_EXTERNAL_COUNT_PIN_I;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_tick
            logic [15:0] ctl;
            assign ctl = (g == 0) ? lower_ctrl_r : upper_ctrl_r;
            assign ext_sel[g] = ctl[tmr_pair_pkg::CTRL_SRC_BIT];
            assign gate_en[g] = ctl[tmr_pair_pkg::CTRL_GATE_BIT] & ~ctl[tmr_pair_pkg::CTRL_SRC_BIT];
            assign div_sel[g] = ctl[tmr_pair_pkg::CTRL_DIV_LSB +: 2];
            tmr_tick_gen #(
                .SYNC_AFTER(g == 0)
            ) u_tick (
                .clk_i(CLK_I),
                .rst_b_i(RST_B_I),
                .run_i(run[g]),
                .ext_sel_i(ext_sel[g]),
                .gate_en_i(gate_en[g]),
                .div_sel_i(div_sel[g]),
                .pin_i(pin[g]),
                .tick_o(tick[g]),
                .gate_fall_o(gate_fall[g])
            );
        end
    endgenerate

    assign count32 = {upper_count_r, lower_count_r};
    assign period32 = {upper_period_r, lower_period_r};
    assign lo_match = lower_count_r == lower_period_r;
    assign hi_match = upper_count_r == upper_period_r;
    assign pair_match = count32 == period32;

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            lower_count_r <= tmr_pair_pkg::COUNT_RESET;
        end else if (wr_cnt_lo) begin
            lower_count_r <= HWDATA_I[15:0];
        end else if (tick[0]) begin
            lower_count_r <= (pair ? pair_match : lo_match) ? tmr_pair_pkg::COUNT_RESET
                                                             : lower_count_r + 16'h0001;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            upper_count_r <= tmr_pair_pkg::COUNT_RESET;
        end else if (wr_cnt_hi) begin
            upper_count_r <= HWDATA_I[15:0];
        end else if (pair && tick[0]) begin
            if (pair_match) begin
                upper_count_r <= tmr_pair_pkg::COUNT_RESET;
            end else if (&lower_count_r) begin
                upper_count_r <= upper_count_r + 16'h0001;
            end
        end else if (!pair && tick[1]) begin
            upper_count_r <= hi_match ? tmr_pair_pkg::COUNT_RESET : upper_count_r + 16'h0001;
        end
    end

    // Period match flags outside gated mode; gate fall flags inside it
    always_comb begin
        irq_set = 2'h0;
        if (pair) begin
            irq_set[tmr_pair_pkg::IRQ_UPPER_BIT] = gate_en[0] ? gate_fall[0] : tick[0] & pair_match;
        end else begin
            irq_set[tmr_pair_pkg::IRQ_LOWER_BIT] = gate_en[0] ? gate_fall[0] : tick[0] & lo_match;
            irq_set[tmr_pair_pkg::IRQ_UPPER_BIT] = gate_en[1] ? gate_fall[1] : tick[1] & hi_match;
        end
    end

    // Set beats a write-one clear in the same cycle
    assign irq_status_nxt = (irq_status_r & ~(wr_stat ? HWDATA_I[1:0] : 2'h0)) | irq_set;
    assign irq_live = irq_status_r & irq_enable_r & {1'b1, ~pair};

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            irq_status_r <= 2'h0;
            IRQ_O <= 1'b0;
            IRQ_PRIO_O <= 3'h0;
        end else begin
            irq_status_r <= irq_status_nxt;
            IRQ_O <= |irq_live;
            if (irq_live[tmr_pair_pkg::IRQ_UPPER_BIT]) begin
                IRQ_PRIO_O <= irq_prio_r[tmr_pair_pkg::PRIO_UPPER_LSB +: tmr_pair_pkg::PRIO_W];
            end else if (irq_live[tmr_pair_pkg::IRQ_LOWER_BIT]) begin
                IRQ_PRIO_O <= irq_prio_r[tmr_pair_pkg::PRIO_W-1:0];
            end else begin
                IRQ_PRIO_O <= 3'h0;
            end
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);

    bus_always_okay_a: assert property (HREADYOUT_O && !HRESP_O)
        else $error("slave not ready or error response");
    irq_follows_status_a: assert property (|irq_live |=> IRQ_O)
        else $error("interrupt not raised for enabled flag");
    pair_lower_quiet_a: assert property (pair && !wr_stat |=> !$rose(irq_status_r[0]))
        else $error("lower flag set in pair mode");
    lower_wrap_a: assert property (!pair && tick[0] && lo_match && !gate_en[0] && !wr_cnt_lo
        |=> lower_count_r == 16'h0000 && irq_status_r[0])
        else $error("lower timer did not wrap and flag");
    lower_incr_a: assert property (!pair && tick[0] && !lo_match && !wr_cnt_lo
        |=> lower_count_r == $past(lower_count_r) + 16'h0001)
        else $error("lower timer did not increment");
    stopped_hold_a: assert property (!run[0] && !wr_cnt_lo |=> $stable(lower_count_r))
        else $error("stopped lower timer changed");
    idle_halt_a: assert property (IDLE_I && lower_ctrl_r[tmr_pair_pkg::CTRL_IDLE_BIT] |-> !tick[0])
        else $error("timer ticked while idle halted");
    pair_carry_a: assert property (pair && tick[0] && !pair_match && &lower_count_r && !wr_cnt_hi
        |=> upper_count_r == $past(upper_count_r) + 16'h0001)
        else $error("pair carry missing");
    pair_upper_off_a: assert property (pair |-> !run[1])
        else $error("upper timer runs on its own in pair mode");
    ext_gate_ignored_a: assert property (ext_sel[0] |-> !gate_fall[0])
        else $error("gate acted with external clock");
    gate_flag_a: assert property (!pair && gate_fall[0] |=> irq_status_r[0])
        else $error("gate fall did not flag");
    upper_wrap_a: assert property (!pair && tick[1] && hi_match && !gate_en[1] && !wr_cnt_hi
        |=> upper_count_r == tmr_pair_pkg::COUNT_RESET && irq_status_r[tmr_pair_pkg::IRQ_UPPER_BIT])
        else $error("upper timer did not wrap and flag");
    upper_incr_a: assert property (!pair && tick[1] && !hi_match && !wr_cnt_hi
        |=> upper_count_r == $past(upper_count_r) + 16'h0001)
        else $error("upper timer did not increment");
    upper_hold_a: assert property (!pair && !run[1] && !wr_cnt_hi |=> $stable(upper_count_r))
        else $error("stopped upper timer changed");
    pair_wrap_a: assert property (pair && tick[0] && pair_match && !gate_en[0]
        && !wr_cnt_lo && !wr_cnt_hi
        |=> lower_count_r == tmr_pair_pkg::COUNT_RESET && upper_count_r == tmr_pair_pkg::COUNT_RESET
        && irq_status_r[tmr_pair_pkg::IRQ_UPPER_BIT])
        else $error("pair timer did not wrap and flag");
    pair_no_carry_a: assert property (pair && tick[0] && !pair_match && !(&lower_count_r) && !wr_cnt_hi
        |=> $stable(upper_count_r))
        else $error("upper word moved without carry");
    pair_idle_a: assert property (pair && IDLE_I && upper_ctrl_r[tmr_pair_pkg::CTRL_IDLE_BIT]
        |-> !tick[0])
        else $error("pair ran while upper idle halt set");
    upper_gate_off_a: assert property (ext_sel[1] |-> !gate_fall[1])
        else $error("upper gate acted with external clock");
    upper_gate_flag_a: assert property (!pair && gate_fall[1]
        |=> irq_status_r[tmr_pair_pkg::IRQ_UPPER_BIT])
        else $error("upper gate fall did not flag");
    irq_prio_a: assert property (irq_live[tmr_pair_pkg::IRQ_UPPER_BIT] && !wr_prio
        |=> IRQ_PRIO_O == irq_prio_r[tmr_pair_pkg::PRIO_UPPER_LSB +: tmr_pair_pkg::PRIO_W])
        else $error("upper priority not reported");
    irq_quiet_a: assert property (irq_live == 2'h0 |=> !IRQ_O)
        else $error("interrupt raised with no enabled flag");
    status_read_a: assert property (addr_ok && !HWRITE_I && HADDR_I[7:0] == tmr_pair_pkg::IRQ_STATUS_ADDR
        |=> HRDATA_O == {30'h0, $past(irq_status_r)})
        else $error("status read returned wrong data");
    read_idle_zero_a: assert property (!(addr_ok && !HWRITE_I) |=> HRDATA_O == 32'h0000_0000)
        else $error("read data not cleared outside a read");

    pair_wrap_c: cover property (pair && tick[0] && pair_match);
    gate_fall_c: cover property (gate_fall[0]);
    ext_tick_c: cover property (ext_sel[0] && tick[0]);
    irq_raise_c: cover property ($rose(IRQ_O));
    upper_wrap_c: cover property (!pair && tick[1] && hi_match);
endmodule
`default_nettype wire

//--- tb/tmr_pair_tb.sv
`default_nettype none
module tmr_pair_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] A_LC = tmr_pair_pkg::LOWER_TIMER_CONTROL_ADDR;
    localparam logic [7:0] A_UC = tmr_pair_pkg::UPPER_TIMER_CONTROL_ADDR;
    localparam logic [7:0] A_LN = tmr_pair_pkg::LOWER_COUNT_ADDR;
    localparam logic [7:0] A_UN = tmr_pair_pkg::UPPER_COUNT_ADDR;
    localparam logic [7:0] A_LP = tmr_pair_pkg::LOWER_PERIOD_ADDR;
    localparam logic [7:0] A_UP = tmr_pair_pkg::UPPER_PERIOD_ADDR;
    localparam logic [7:0] A_ST = tmr_pair_pkg::IRQ_STATUS_ADDR;
    localparam logic [7:0] A_EN = tmr_pair_pkg::IRQ_ENABLE_ADDR;
    localparam logic [7:0] A_PR = tmr_pair_pkg::IRQ_PRIORITY_ADDR;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic lo_pin = 1'b0;
    logic up_pin = 1'b0;
    logic idle = 1'b0;
    logic irq;
    logic [2:0] prio;
    logic [31:0] rdv;
    int errors = 0;
    int samples_checked = 0;
    int sh;
    always #4 clk = ~clk;
    tmr_pair u_tmr_pair (.CLK_I(clk), .RST_B_I(rst_b), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hreadyout), .HRDATA_O(hrdata),
        .HREADYOUT_O(hreadyout), .HRESP_O(hresp), .LOWER_EXTERNAL_COUNT_PIN_I(lo_pin),
        .UPPER_EXTERNAL_COUNT_PIN_I(up_pin), .IDLE_I(idle), .IRQ_O(irq), .IRQ_PRIO_O(prio));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        samples_checked++;
        if ($isunknown(got) || got < lo || got > hi) begin
            errors++;
            $display("FAIL t=%0t got %h range %h..%h", $time, got, lo, hi);
        end
    endtask
    // Bounded wait for hready sampled high at a rising edge
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 16);
        if (hreadyout !== 1'b1) begin
            errors++;
            $display("FAIL t=%0t bus hang", $time);
            tally_and_finish();
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic wr_en, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= tmr_pair_pkg::HTRANS_NONSEQ;
        hwrite <= wr_en;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rdv = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(rdv, exp);
    endtask
    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, errors);
    endtask
    // Runs the joined pair for about 64 ticks from {up0, FFF0}
    task automatic pair_run(input logic [31:0] up0, input logic [31:0] up_exp, input logic [31:0] lo_min);
        wr(A_LN, 32'hFFF0);
        wr(A_UN, up0);
        wr(A_LC, 32'h8008);
        repeat (62) @(posedge clk);
        wr(A_LC, 32'h0008);
        rdc(A_UN, up_exp);
        xfer(A_LN, 1'b0, 32'h0);
        chk_rng(rdv, lo_min, lo_min + 6);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk(32'({hresp, irq, prio}), 32'h0);
        for (int i = 0; i < 10; i++) begin
            rdc(8'(i * 4), (i == 4 || i == 5) ? {16'h0, tmr_pair_pkg::PERIOD_RESET} : 32'h0);
        end
        wr(A_LC, 32'hFFFF_7FFF);
        rdc(A_LC, 32'h0000_207A);
        wr(A_UC, 32'hFFFF_7FFF);
        rdc(A_UC, 32'h0000_2072);
        wr(A_LC, 32'h0);
        wr(A_UC, 32'h0);
        wr(8'h24, 32'h1234_5678);
        rdc(8'h24, 32'h0);
        end_test("registers");
        for (int t = 0; t < 2; t++) begin
            for (int d = 0; d < 4; d++) begin
                sh = (d == 3) ? 8 : 3 * d;
                wr(t ? A_UN : A_LN, 32'h0);
                wr(t ? A_UC : A_LC, 32'h8000 | 32'(d << 4));
                repeat (510) @(posedge clk);
                wr(t ? A_UC : A_LC, 32'h0);
                xfer(t ? A_UN : A_LN, 1'b0, 32'h0);
                chk_rng(rdv, 32'((512 >> sh) - 2), 32'((512 >> sh) + 2));
            end
        end
        end_test("prescale");
        wr(A_LP, 32'h3);
        wr(A_LN, 32'h0);
        wr(A_PR, 32'h15);
        wr(A_LC, 32'h8000);
        repeat (8) @(posedge clk);
        wr(A_LC, 32'h0);
        xfer(A_LN, 1'b0, 32'h0);
        chk_rng(rdv, 32'h0, 32'h3);
        rdc(A_ST, 32'h1);
        chk(32'(irq), 32'h0);
        wr(A_EN, 32'h1);
        rdc(A_ST, 32'h1);
        chk(32'({irq, prio}), 32'hD);
        wr(A_ST, 32'h1);
        rdc(A_ST, 32'h0);
        chk(32'(irq), 32'h0);
        end_test("irq");
        wr(A_LP, 32'hFFF8);
        wr(A_UP, 32'h1);
        wr(A_UC, 32'h0030);
        pair_run(32'h0, 32'h1, 32'h2D);
        rdc(A_ST, 32'h0);
        pair_run(32'h1, 32'h0, 32'h34);
        rdc(A_ST, 32'h2);
        chk(32'(irq), 32'h0);
        wr(A_EN, 32'h2);
        rdc(A_ST, 32'h2);
        chk(32'({irq, prio}), 32'hA);
        wr(A_ST, 32'h3);
        wr(A_EN, 32'h0);
        end_test("pair");
        idle <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            wr(A_LN, 32'h0);
            wr(A_UC, (k == 2) ? 32'h2000 : 32'h0);
            wr(A_LC, (k == 0) ? 32'hA000 : ((k == 1) ? 32'h8000 : 32'h8008));
            repeat (60) @(posedge clk);
            wr(A_LC, 32'h0);
            xfer(A_LN, 1'b0, 32'h0);
            chk_rng(rdv, (k == 1) ? 32'd59 : 32'd0, (k == 1) ? 32'd65 : 32'd0);
        end
        idle <= 1'b0;
        end_test("idle");
        wr(A_LN, 32'h0);
        wr(A_UN, 32'h0);
        wr(A_UC, 32'h8052);
        wr(A_LC, 32'h8012);
        repeat (15) begin
            lo_pin <= 1'b1;
            up_pin <= 1'b1;
            repeat (4) @(posedge clk);
            lo_pin <= 1'b0;
            up_pin <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (8) @(posedge clk);
        rdc(A_LN, 32'h1);
        rdc(A_UN, 32'h1);
        wr(A_LC, 32'h0);
        wr(A_UC, 32'h0);
        end_test("external");
        wr(A_LN, 32'h0);
        wr(A_LC, 32'h8040);
        lo_pin <= 1'b1;
        rdc(A_ST, 32'h0);
        repeat (18) @(posedge clk);
        lo_pin <= 1'b0;
        repeat (6) @(posedge clk);
        rdc(A_ST, 32'h1);
        wr(A_LC, 32'h0);
        xfer(A_LN, 1'b0, 32'h0);
        chk_rng(rdv, 32'd18, 32'd22);
        end_test("gated");
        tally_and_finish();
    end
endmodule
`default_nettype wire
